// ### design/debug_support_register_bank.sv
// development-support register bank reached by register moves
// What this block does
// [R1] registers reached only through register move numbers
// [R2] decode numbers 144-159 and 630 to registers
// [R3] supervisor read, debug off: read, clear cause
// [R4] debug on, not halted: read, keep cause
// [R5] halted in debug: read, cause read clears
// [R6] user read: exception, no read, no clear
// [R7] allowed writes performed, port data only when halted in debug, cause writes always ignored
// [R8] debug on, not halted: whole write discarded
// [R9] user write: exception, write not performed
// [R10] comparators A-D hold thirty address bits
// [R11] comparators E-F hold full address words
// [R12] comparators G-H hold full data words
// [R13] fetch control packs compare, watch, trap fields
// [R14] compare type decoded off, eq, lt, gt, ne
// [R15] port trap enables read-only to software
// [R16] new show-cycle value acts after one following instruction
// [R17] fetch control cleared by reset
`timescale 1ns/1ps
`include "debug_bank_params.svh"

module debug_support_register_bank (
    input wire logic mclk,
    input wire logic rst_b,
    input wire debug_pkg::spr_request_t spr_req,
    input wire logic user_privilege_flag,
    input wire logic debug_mode_enable,
    input wire logic in_debug_mode,
    input wire logic instr_done,
    input wire logic [31:0] cause_events,
    input wire logic port_data_load,
    input wire logic [31:0] port_data_in,
    input wire logic port_trap_load,
    input wire logic [3:0] port_trap_value,
    output logic spr_ack,
    output logic [31:0] spr_rdata,
    output logic program_exception,
    output logic [31:0] debug_cause,
    output logic [31:0] debug_event_enable,
    output debug_pkg::fetch_bus_control_t fetch_bus_control,
    output logic [1:0] show_cycle_active,
    output debug_pkg::compare_kind_t [3:0] compare_kind,
    output logic [31:0] port_data
);
    localparam int unsigned BANK_SIZE = 16;

    // ==========================================================
    // decode
    logic [9:0] bank_offset;
    logic [3:0] bank_idx;
    logic hit_bank;
    logic hit_port;
    logic hit;
    logic is_cause;
    logic is_fetch_ctrl;
    logic raise_exception;
    logic do_read;
    logic clear_cause;
    logic port_read_valid;
    logic do_write;
    logic write_fetch_ctrl;

    always_comb
    begin
        bank_offset = spr_req.num - `SPR_BANK_FIRST;
        bank_idx = bank_offset[3:0];
        // see [R1] [R2]
        hit_bank = spr_req.num >= `SPR_BANK_FIRST
            && spr_req.num <= `SPR_BANK_LAST;
        hit_port = spr_req.num == `SPR_PORT_DATA; // see [R2]
        hit = spr_req.valid && (hit_bank || hit_port);
        is_cause = spr_req.num == `SPR_CAUSE;
        is_fetch_ctrl = spr_req.num == `SPR_FETCH_CTRL;
        write_fetch_ctrl = hit && do_write && is_fetch_ctrl;
    end

    spr_access_policy u_policy (
        .user_privilege_flag(user_privilege_flag),
        .debug_mode_enable(debug_mode_enable),
        .in_debug_mode(in_debug_mode),
        .is_write(spr_req.write),
        .is_cause(is_cause),
        .is_port(hit_port),
        .raise_exception(raise_exception),
        .do_read(do_read),
        .clear_cause(clear_cause),
        .port_read_valid(port_read_valid),
        .do_write(do_write)
    );

    // ==========================================================
    // register bank, one entry per number 144 to 159
    logic [31:0] bank_q [BANK_SIZE];
    logic [31:0] bank_d [BANK_SIZE];

    generate
        for (genvar i = 0; i < BANK_SIZE; i++)
        begin : g_entry
            localparam logic [3:0] IDX = 4'(i);
            localparam logic [31:0] MASK =
                (i <= `IDX_LAST_SHORT_CMP) ? `SHORT_CMP_MASK :
                (i == `IDX_FETCH_CTRL) ? ~`PORT_TRAP_MASK :
                32'hffffffff;
            localparam logic [31:0] RST =
                (i == `IDX_FETCH_CTRL) ? `FETCH_CTRL_RESET : `BANK_RESET;
            logic entry_write;

            always_comb
            begin
                entry_write = hit && hit_bank && do_write && bank_idx == IDX;
                bank_d[i] = bank_q[i];
                if (entry_write)
                begin
                    // see [R10] [R11] [R12] [R13] [R15]
                    bank_d[i] = (bank_q[i] & ~MASK) | (spr_req.wdata & MASK);
                end
                if (i == `IDX_CAUSE)
                begin
                    if (hit && clear_cause)
                    begin
                        bank_d[i] = `BANK_RESET; // see [R3] [R5]
                    end
                    // new events win over a clearing read
                    bank_d[i] = bank_d[i] | cause_events;
                end
                if (i == `IDX_FETCH_CTRL && port_trap_load)
                begin
                    bank_d[i][`PORT_TRAP_LSB +: 4] = port_trap_value;
                end
            end

            always_ff @(posedge mclk)
            begin
                if (!rst_b)
                begin
                    bank_q[i] <= RST; // see [R17]
                end
                else
                begin
                    bank_q[i] <= bank_d[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // port data word, shared with the serial port side
    logic [31:0] port_q;
    logic [31:0] port_d;

    always_comb
    begin
        port_d = port_q;
        if (port_data_load)
        begin
            port_d = port_data_in;
        end
        if (hit && hit_port && do_write)
        begin
            port_d = spr_req.wdata; // see [R7] [R8]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            port_q <= `BANK_RESET;
        end
        else
        begin
            port_q <= port_d;
        end
    end

    // ==========================================================
    // answer to the core
    logic ack_q;
    logic ack_d;
    logic exc_q;
    logic exc_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb
    begin
        ack_d = hit;
        exc_d = hit && raise_exception; // see [R6] [R9]
        rdata_d = 32'h00000000;
        if (hit && do_read)
        begin
            if (hit_port)
            begin
                // indeterminate outside debug mode, shown as zero
                rdata_d = port_read_valid ? port_q : 32'h00000000;
            end
            else
            begin
                rdata_d = bank_q[bank_idx]; // see [R3] [R4] [R5]
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
            exc_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= ack_d;
            exc_q <= exc_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // show-cycle select delayed by one following instruction
    logic pend_q;
    logic pend_d;
    logic [1:0] pend_val_q;
    logic [1:0] pend_val_d;
    logic [1:0] show_q;
    logic [1:0] show_d;

    always_comb
    begin
        pend_d = pend_q;
        pend_val_d = pend_val_q;
        show_d = show_q;
        if (pend_q && instr_done)
        begin
            show_d = pend_val_q; // see [R16]
            pend_d = 1'b0;
        end
        if (write_fetch_ctrl)
        begin
            pend_d = 1'b1; // see [R16]
            pend_val_d = spr_req.wdata[`SHOW_CYCLE_LSB +: 2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            pend_q <= 1'b0;
            pend_val_q <= `SHOW_CYCLE_RESET;
            show_q <= `SHOW_CYCLE_RESET;
        end
        else
        begin
            pend_q <= pend_d;
            pend_val_q <= pend_val_d;
            show_q <= show_d;
        end
    end

    // ==========================================================
    // decoded compare kinds of the four fetch comparators
    debug_pkg::fetch_bus_control_t fetch_ctrl;
    logic [2:0] type_field [4];
    debug_pkg::compare_kind_t kind_d [4];
    debug_pkg::compare_kind_t [3:0] kind_q;

    always_comb
    begin
        fetch_ctrl = bank_q[`IDX_FETCH_CTRL];
        type_field[0] = fetch_ctrl.compare_type_first;
        type_field[1] = fetch_ctrl.compare_type_second;
        type_field[2] = fetch_ctrl.compare_type_third;
        type_field[3] = fetch_ctrl.compare_type_fourth;
    end

    generate
        for (genvar k = 0; k < 4; k++)
        begin : g_kind
            compare_type_decode u_decode (
                .compare_type(type_field[k]),
                .kind(kind_d[k])
            );

            always_ff @(posedge mclk)
            begin
                if (!rst_b)
                begin
                    kind_q[k] <= debug_pkg::CMP_OFF;
                end
                else
                begin
                    kind_q[k] <= kind_d[k]; // see [R14]
                end
            end
        end
    endgenerate

    // ==========================================================
    // outputs
    assign spr_ack = ack_q;
    assign spr_rdata = rdata_q;
    assign program_exception = exc_q;
    assign debug_cause = bank_q[`IDX_CAUSE];
    assign debug_event_enable = bank_q[5];
    assign fetch_bus_control = bank_q[`IDX_FETCH_CTRL];
    assign show_cycle_active = show_q;
    assign compare_kind = kind_q;
    assign port_data = port_q;

    // ==========================================================
    // checks
    a_user_read_exc: assert property ( // see [R6] [R9]
        @(posedge mclk) disable iff (!rst_b)
        hit && user_privilege_flag |=> exc_q && ack_q
        && rdata_q == 32'h00000000)
        else $error("user access did not raise exception");

    a_user_keeps_cause: assert property ( // see [R6]
        @(posedge mclk) disable iff (!rst_b)
        hit && is_cause && user_privilege_flag && cause_events == 32'h0
        |=> $stable(bank_q[`IDX_CAUSE]))
        else $error("user access changed cause");

    a_read_clears_cause: assert property (@(posedge mclk) // see [R3] [R5]
        disable iff (!rst_b)
        hit && is_cause && !spr_req.write && !user_privilege_flag
        && (!debug_mode_enable || in_debug_mode) && cause_events == 32'h0
        |=> bank_q[`IDX_CAUSE] == 32'h0
        && rdata_q == $past(bank_q[`IDX_CAUSE]))
        else $error("cause not cleared by read");

    a_read_keeps_cause: assert property (@(posedge mclk) // see [R4]
        disable iff (!rst_b)
        hit && is_cause && !spr_req.write && !user_privilege_flag
        && debug_mode_enable && !in_debug_mode && cause_events == 32'h0
        |=> $stable(bank_q[`IDX_CAUSE]))
        else $error("cause cleared outside debug mode");

    a_cause_write_ignored: assert property (@(posedge mclk) // see [R7]
        disable iff (!rst_b)
        hit && is_cause && spr_req.write && cause_events == 32'h0
        && !(~spr_req.wdata == 32'h0 && bank_q[`IDX_CAUSE] == 32'h0)
        |=> $stable(bank_q[`IDX_CAUSE]))
        else $error("cause register took a write");

    a_port_write_discard: assert property (@(posedge mclk) // see [R7] [R8]
        disable iff (!rst_b)
        hit && hit_port && spr_req.write && !port_data_load
        && (!debug_mode_enable || !in_debug_mode)
        |=> $stable(port_q))
        else $error("port data written when not allowed");

    a_port_write_done: assert property (@(posedge mclk) // see [R7]
        disable iff (!rst_b)
        hit && hit_port && spr_req.write && !user_privilege_flag
        && debug_mode_enable && in_debug_mode
        |=> port_q == $past(spr_req.wdata))
        else $error("port data write lost in debug mode");

    a_port_trap_ro: assert property ( // see [R13] [R15]
        @(posedge mclk) disable iff (!rst_b)
        write_fetch_ctrl && !port_trap_load
        |=> $stable(bank_q[`IDX_FETCH_CTRL][`PORT_TRAP_LSB +: 4])
        && bank_q[`IDX_FETCH_CTRL][31:8] == $past(spr_req.wdata[31:8]))
        else $error("port trap bits written by software");

    a_short_cmp_mask: assert property ( // see [R10]
        @(posedge mclk) disable iff (!rst_b)
        hit && do_write && spr_req.num == `SPR_CMP_A
        |=> bank_q[0] == {$past(spr_req.wdata[31:2]), $past(bank_q[0][1:0])})
        else $error("comparator A reserved bits written");

    a_show_delay: assert property ( // see [R16]
        @(posedge mclk) disable iff (!rst_b)
        write_fetch_ctrl && !(pend_q && instr_done)
        |=> show_q == $past(show_q) ##0 (!instr_done [*1] ##1 1'b1)
        or (instr_done ##1 show_q == $past(spr_req.wdata[1:0], 2)))
        else $error("show-cycle select applied at wrong time");

    a_fetch_reset: assert property (@(posedge mclk) // see [R17]
        !rst_b |=> bank_q[`IDX_FETCH_CTRL] == 32'h0 && show_q == 2'h0)
        else $error("fetch control not cleared by reset");

    a_kind_off: assert property ( // see [R14]
        @(posedge mclk) disable iff (!rst_b)
        !bank_q[`IDX_FETCH_CTRL][31] && $stable(bank_q[`IDX_FETCH_CTRL])
        |=> kind_q[0] == debug_pkg::CMP_OFF)
        else $error("inactive comparator decoded as active");

endmodule : debug_support_register_bank

// ### design/debug_bank_params.svh
// register numbers, field masks and reset values of the debug register bank
`ifndef DEBUG_BANK_PARAMS_SVH
`define DEBUG_BANK_PARAMS_SVH

// ==========================================================
// register numbers
`define SPR_CMP_A 10'h090
`define SPR_CMP_B 10'h091
`define SPR_CMP_C 10'h092
`define SPR_CMP_D 10'h093
`define SPR_CAUSE 10'h094
`define SPR_EVENT_ENABLE 10'h095
`define SPR_COUNTER_A 10'h096
`define SPR_COUNTER_B 10'h097
`define SPR_CMP_E 10'h098
`define SPR_CMP_F 10'h099
`define SPR_CMP_G 10'h09a
`define SPR_CMP_H 10'h09b
`define SPR_LOAD_CTRL_ONE 10'h09c
`define SPR_LOAD_CTRL_TWO 10'h09d
`define SPR_FETCH_CTRL 10'h09e
`define SPR_BREAK_ADDR 10'h09f
`define SPR_PORT_DATA 10'h276
`define SPR_BANK_FIRST `SPR_CMP_A
`define SPR_BANK_LAST `SPR_BREAK_ADDR

// ==========================================================
// bank entry indices (register number minus first number)
`define IDX_CAUSE 4'h4
`define IDX_FETCH_CTRL 4'he
`define IDX_LAST_SHORT_CMP 4'h3

// ==========================================================
// field masks, field bit 0 sits at vector bit 31
`define SHORT_CMP_MASK 32'hfffffffc
`define PORT_TRAP_MASK 32'h000000f0
`define PORT_TRAP_LSB 5'h04
`define SHOW_CYCLE_LSB 5'h00

// ==========================================================
// reset values
`define BANK_RESET 32'h00000000
`define FETCH_CTRL_RESET 32'h00000000
`define SHOW_CYCLE_RESET 2'h0

`endif

// ### design/debug_pkg.sv
// types shared by the debug register bank
package debug_pkg;

    // ==========================================================
    // fetch bus control word, first field in the top bits
    typedef struct packed {
        logic [2:0] compare_type_first;
        logic [2:0] compare_type_second;
        logic [2:0] compare_type_third;
        logic [2:0] compare_type_fourth;
        logic [1:0] fetch_watchpoint_first;
        logic [1:0] fetch_watchpoint_second;
        logic [1:0] fetch_watchpoint_third;
        logic [1:0] fetch_watchpoint_fourth;
        logic [3:0] software_trap_enable;
        logic [3:0] port_trap_enable;
        logic skip_first_match;
        logic fetch_sync_disable;
        logic [1:0] show_cycle_select;
    } fetch_bus_control_t;

    // ==========================================================
    // one register move from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [9:0] num;
        logic [31:0] wdata;
    } spr_request_t;

    // ==========================================================
    // decoded instruction comparator kind
    typedef enum logic [2:0] {
        CMP_OFF = 3'h0,
        CMP_EQ = 3'h1,
        CMP_LT = 3'h3,
        CMP_GT = 3'h2,
        CMP_NE = 3'h6
    } compare_kind_t;

endpackage : debug_pkg

// ### design/spr_access_policy.sv
// privilege and debug-state gate for register moves
`timescale 1ns/1ps
`include "debug_bank_params.svh"

module spr_access_policy (
    input wire logic user_privilege_flag,
    input wire logic debug_mode_enable,
    input wire logic in_debug_mode,
    input wire logic is_write,
    input wire logic is_cause,
    input wire logic is_port,
    output logic raise_exception,
    output logic do_read,
    output logic clear_cause,
    output logic port_read_valid,
    output logic do_write
);
    logic allowed_state;

    always_comb
    begin
        allowed_state = !debug_mode_enable || in_debug_mode;
        raise_exception = user_privilege_flag; // see [R6] [R9]
        do_read = !is_write && !user_privilege_flag; // see [R3] [R4] [R5]
        clear_cause = do_read && is_cause && allowed_state; // see [R3] [R5]
        port_read_valid = debug_mode_enable && in_debug_mode; // see [R4]
        // see [R7] [R8]
        do_write = is_write && !user_privilege_flag && allowed_state
            && !is_cause && !(is_port && !debug_mode_enable);
    end

endmodule : spr_access_policy

// ### design/compare_type_decode.sv
// decodes one 3-bit instruction compare-type field
`timescale 1ns/1ps

module compare_type_decode (
    input wire logic [2:0] compare_type,
    output debug_pkg::compare_kind_t kind
);
    always_comb
    begin
        // see [R14]
        case (compare_type)
            3'h4: kind = debug_pkg::CMP_EQ;
            3'h5: kind = debug_pkg::CMP_LT;
            3'h6: kind = debug_pkg::CMP_GT;
            3'h7: kind = debug_pkg::CMP_NE;
            default: kind = debug_pkg::CMP_OFF;
        endcase
    end

endmodule : compare_type_decode

// ### tb/core_move_model.sv
// core-side model issuing register moves and instruction completions
`timescale 1ns/1ps

module core_move_model (
    input wire logic mclk,
    output debug_pkg::spr_request_t spr_req,
    output logic user_privilege_flag,
    output logic instr_done
);
    // ==========================================================
    // idle state
    initial
    begin
        spr_req = '0;
        user_privilege_flag = 1'b0;
        instr_done = 1'b0;
    end

    // ==========================================================
    // one move; returns while the one-cycle answer stands
    task automatic move(input logic usr, input logic wr,
        input logic [9:0] num, input logic [31:0] wd);
        @(posedge mclk);
        spr_req <= '{valid: 1'b1, write: wr, num: num,
            wdata: wd};
        user_privilege_flag <= usr;
        @(posedge mclk);
        // released bus shows the inverse, never stale request data
        spr_req <= '{valid: 1'b0, write: ~wr, num: ~num, wdata: ~wd};
        user_privilege_flag <= ~usr;
        #1;
    endtask : move

    // ==========================================================
    // one completed instruction
    task automatic instr();
        @(posedge mclk);
        instr_done <= 1'b1;
        @(posedge mclk);
        instr_done <= 1'b0;
        #1;
    endtask : instr
endmodule : core_move_model

// ### tb/debug_support_register_bank_tb_top.sv
// self-checking testbench of the debug register bank
`timescale 1ns/1ps
`include "debug_bank_params.svh"

module debug_support_register_bank_tb_top;
    logic mclk, rst_b, debug_mode_enable, in_debug_mode;
    logic port_data_load, port_trap_load, user_privilege_flag, instr_done;
    logic [31:0] cause_events, port_data_in, spr_rdata, debug_cause;
    logic [31:0] debug_event_enable, port_data;
    logic [3:0] port_trap_value;
    logic spr_ack, program_exception;
    logic [1:0] show_cycle_active;
    debug_pkg::spr_request_t spr_req;
    debug_pkg::fetch_bus_control_t fetch_bus_control;
    debug_pkg::compare_kind_t [3:0] compare_kind;
    int n_fail, comparisons;
    logic [33:0] answer;

    assign answer = {spr_ack, program_exception, spr_rdata};

    core_move_model i_core_move_model (.mclk(mclk), .spr_req(spr_req),
        .user_privilege_flag(user_privilege_flag), .instr_done(instr_done));

    debug_support_register_bank i_debug_support_register_bank (
        .mclk(mclk), .rst_b(rst_b), .spr_req(spr_req),
        .user_privilege_flag(user_privilege_flag),
        .debug_mode_enable(debug_mode_enable), .in_debug_mode(in_debug_mode),
        .instr_done(instr_done), .cause_events(cause_events),
        .port_data_load(port_data_load), .port_data_in(port_data_in),
        .port_trap_load(port_trap_load), .port_trap_value(port_trap_value),
        .spr_ack(spr_ack), .spr_rdata(spr_rdata),
        .program_exception(program_exception), .debug_cause(debug_cause),
        .debug_event_enable(debug_event_enable),
        .fetch_bus_control(fetch_bus_control),
        .show_cycle_active(show_cycle_active), .compare_kind(compare_kind),
        .port_data(port_data));

    // ==========================================================
    // helpers
    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [33:0] seen,
        input logic [33:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic acc(input logic usr, input logic wr, input logic [9:0] n,
        input logic [31:0] wd);
        i_core_move_model.move(usr, wr, n, wd);
    endtask : acc

    task automatic mode(input logic e, input logic h);
        @(posedge mclk);
        debug_mode_enable <= e;
        in_debug_mode <= h;
    endtask : mode

    task automatic side(input logic [31:0] ev, input logic pl,
        input logic [31:0] pd, input logic tl, input logic [3:0] tv);
        @(posedge mclk);
        cause_events <= ev;
        port_data_load <= pl;
        port_data_in <= pd;
        port_trap_load <= tl;
        port_trap_value <= tv;
        @(posedge mclk);
        cause_events <= '0;
        port_data_load <= 1'b0;
        port_trap_load <= 1'b0;
        #1;
    endtask : side

    function automatic logic [31:0] wv(input logic [9:0] n);
        return 32'hc3a5_0003 ^ {22'h0, n};
    endfunction : wv

    // ==========================================================
    // scenarios
    task automatic t_reset();
        check("fetch_rst", {2'h0, fetch_bus_control}, 34'h0);
        acc(1'b0, 1'b0, `SPR_FETCH_CTRL, 32'h0);
        check("fetch_rd", answer, {2'b10, 32'h0});
    endtask : t_reset

    task automatic t_bank();
        logic [31:0] e;
        logic [1:0] st;
        for (int n = 144; n <= 160; n++)
        begin
            if (n == 148)
                continue;
            e = (n <= 147) ? (wv(10'(n)) & `SHORT_CMP_MASK) : wv(10'(n));
            if (n == 158)
                e = e & ~`PORT_TRAP_MASK;
            st = (n == 160) ? 2'b00 : 2'b10;
            if (n == 160)
                e = 32'h0;
            acc(1'b0, 1'b1, 10'(n), wv(10'(n)));
            check("wr_ans", answer, {st, 32'h0});
            acc(1'b0, 1'b0, 10'(n), 32'h0);
            check("rd_back", answer, {st, e});
        end
        check("enable", 34'(debug_event_enable), 34'(wv(10'h095)));
    endtask : t_bank

    task automatic t_cause();
        side(32'h0000_8001, 1'b0, 32'h0, 1'b0, 4'h0);
        mode(1'b1, 1'b0);
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("c_keep1", answer, {2'b10, 32'h8001});
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("c_keep2", answer, {2'b10, 32'h8001});
        mode(1'b0, 1'b1);
        acc(1'b0, 1'b1, `SPR_CAUSE, 32'h0);
        check("c_nowr", {2'h0, debug_cause}, {2'h0, 32'h8001});
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("c_rd_off", answer, {2'b10, 32'h8001});
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("c_clr_off", answer, {2'b10, 32'h0});
        side(32'h0040_0000, 1'b0, 32'h0, 1'b0, 4'h0);
        mode(1'b1, 1'b1);
        acc(1'b0, 1'b1, `SPR_CAUSE, 32'hffff_ffff);
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("c_rd_dbg", answer, {2'b10, 32'h0040_0000});
        check("c_clr_dbg", {2'h0, debug_cause}, 34'h0);
    endtask : t_cause

    task automatic t_user();
        logic [33:0] en_exp;
        en_exp = {2'h0, wv(10'h095)};
        side(32'h0000_0002, 1'b0, 32'h0, 1'b0, 4'h0);
        for (int m = 0; m < 2; m++)
        begin
            mode(m[0], m[0]);
            acc(1'b1, 1'b0, `SPR_CAUSE, 32'h0);
            check("u_rd", answer, {2'b11, 32'h0});
            check("u_cause", {2'h0, debug_cause}, {2'h0, 32'h2});
            acc(1'b1, 1'b1, `SPR_EVENT_ENABLE, 32'h0);
            check("u_wr", answer, {2'b11, 32'h0});
            check("u_nowr", {2'h0, debug_event_enable}, en_exp);
        end
        acc(1'b0, 1'b0, `SPR_CAUSE, 32'h0);
        check("u_clr", answer, {2'b10, 32'h2});
    endtask : t_user

    task automatic t_port();
        side(32'h0, 1'b1, 32'h1234_5678, 1'b0, 4'h0);
        for (int m = 0; m < 2; m++)
        begin
            mode(m[0], 1'b0);
            acc(1'b0, 1'b0, `SPR_PORT_DATA, 32'h0);
            check("p_rd_x", answer, {2'b10, 32'h0});
            acc(1'b0, 1'b1, `SPR_PORT_DATA, 32'h0bad_0bad);
            check("p_nowr", 34'(port_data), 34'h1234_5678);
        end
        acc(1'b0, 1'b1, `SPR_COUNTER_A, 32'hffff_0000);
        acc(1'b0, 1'b0, `SPR_COUNTER_A, 32'h0);
        check("drop_wr", answer, {2'b10, wv(10'h096)});
        mode(1'b1, 1'b1);
        acc(1'b0, 1'b0, `SPR_PORT_DATA, 32'h0);
        check("p_rd", answer, {2'b10, 32'h1234_5678});
        acc(1'b0, 1'b1, `SPR_PORT_DATA, 32'h55aa_33cc);
        check("p_wr", 34'(port_data), 34'h55aa_33cc);
    endtask : t_port

    task automatic t_kind();
        logic [2:0] code [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        debug_pkg::compare_kind_t kind [6] = '{debug_pkg::CMP_OFF,
            debug_pkg::CMP_OFF, debug_pkg::CMP_EQ, debug_pkg::CMP_LT,
            debug_pkg::CMP_GT, debug_pkg::CMP_NE};
        mode(1'b0, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            acc(1'b0, 1'b1, `SPR_FETCH_CTRL, {{4{code[i]}}, 20'h0});
            @(posedge mclk);
            #1;
            check("kind", 34'(compare_kind), 34'({4{kind[i]}}));
        end
    endtask : t_kind

    task automatic t_show();
        acc(1'b0, 1'b1, `SPR_FETCH_CTRL, 32'h0000_0a0b);
        check("fields", 34'(fetch_bus_control[11:0]), 34'ha0b);
        repeat (2) @(posedge mclk);
        #1;
        check("show_old", 34'(show_cycle_active), 34'h0);
        i_core_move_model.instr();
        check("show_new", 34'(show_cycle_active), 34'h3);
    endtask : t_show

    task automatic t_trap();
        side(32'h0, 1'b0, 32'h0, 1'b1, 4'h5);
        check("trap_ld", 34'(fetch_bus_control[7:4]), 34'h5);
        acc(1'b0, 1'b1, `SPR_FETCH_CTRL, 32'h0000_0aab);
        check("trap_ro", 34'(fetch_bus_control[11:0]), 34'ha5b);
    endtask : t_trap

    // ==========================================================
    // clock, watchdog, sequence
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        check("watchdog", 34'h1, 34'h0);
        close_out();
    end

    initial
    begin
        rst_b = 1'b0;
        debug_mode_enable = 1'b0;
        in_debug_mode = 1'b0;
        cause_events = '0;
        port_data_load = 1'b0;
        port_data_in = '0;
        port_trap_load = 1'b0;
        port_trap_value = '0;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_bank();
        t_cause();
        t_user();
        t_port();
        t_kind();
        t_show();
        t_trap();
        close_out();
    end
endmodule : debug_support_register_bank_tb_top
